// [rtl/dsa_core.sv]
`timescale 1ns/1ps
module dsa_core
  import dsa_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // analog front end
  input  wire logic             comp_pos,
  output logic                  az_loop,
  output logic                  in_conn,
  output logic                  lo_common,
  output logic                  ref_pos,
  output logic                  ref_neg,
  // display
  input  wire logic             lamp_test,
  output logic                  backplane,
  output logic [SEG_N-1:0]      seg
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic       comp_s1_r, comp_s2_r;
  logic       lt_s1_r, lt_s2_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      lt_s1_r   <= 1'b0;
      lt_s2_r   <= 1'b0;
    end else begin
      comp_s1_r <= comp_pos;
      comp_s2_r <= comp_s1_r;
      lt_s1_r   <= lamp_test;
      lt_s2_r   <= lt_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // count clock and measurement sequence
  // ---------------------------------------------------------------
  dsa_phase_t  ph_r, ph_nxt;
  logic [1:0]  div_r, div_nxt;
  logic        tick;
  logic [11:0] tot_r, tot_nxt;
  logic [11:0] ph_cnt_r, ph_cnt_nxt;
  logic [12:0] bcd_r, bcd_nxt;
  logic [12:0] disp_r, disp_nxt;
  logic        neg_r, neg_nxt;
  logic        disp_neg_r, disp_neg_nxt;
  logic        ri_done;

  function automatic logic [12:0] bcd_inc(input logic [12:0] v);
    logic [12:0] r;
    r = v;
    if (v[3:0] != 4'h9) begin
      r[3:0] = v[3:0] + 4'h1;
    end else begin
      r[3:0] = 4'h0;
      if (v[7:4] != 4'h9) begin
        r[7:4] = v[7:4] + 4'h1;
      end else begin
        r[7:4] = 4'h0;
        if (v[11:8] != 4'h9) begin
          r[11:8] = v[11:8] + 4'h1;
        end else begin
          r[11:8] = 4'h0;
          r[12]   = 1'b1;
        end
      end
    end
    return r;
  endfunction : bcd_inc

  assign tick    = (div_r == 2'(OSC_DIV - 1));
  assign ri_done = (comp_s2_r == neg_r) || (tot_r == 12'(SI_COUNTS + RI_MAX - 1));

  always_comb begin
    div_nxt      = div_r + 2'h1;
    ph_nxt       = ph_r;
    tot_nxt      = tot_r;
    ph_cnt_nxt   = ph_cnt_r;
    bcd_nxt      = bcd_r;
    disp_nxt     = disp_r;
    neg_nxt      = neg_r;
    disp_neg_nxt = disp_neg_r;
    if (tick) begin
      tot_nxt    = tot_r + 12'h001;
      ph_cnt_nxt = ph_cnt_r + 12'h001;
      case (ph_r)
        DSA_AZ: begin
          // auto-zero absorbs whatever the deintegrate left unused
          if (tot_r == 12'(CYCLE_COUNTS - 1)) begin
            ph_nxt     = DSA_SI;
            tot_nxt    = 12'h000;
            ph_cnt_nxt = 12'h000;
          end
        end
        DSA_SI: begin
          if (tot_r == 12'(SI_COUNTS - 1)) begin
            ph_nxt     = DSA_RI;
            ph_cnt_nxt = 12'h000;
            neg_nxt    = ~comp_s2_r;
            bcd_nxt    = 13'h0000;
          end
        end
        DSA_RI: begin
          if (ri_done) begin
            ph_nxt       = DSA_AZ;
            ph_cnt_nxt   = 12'h000;
            disp_nxt     = bcd_r;
            disp_neg_nxt = neg_r;
          end else if (bcd_r != BCD_MAX) begin
            bcd_nxt = bcd_inc(bcd_r);
          end
        end
        default: begin
          ph_nxt     = DSA_AZ;
          ph_cnt_nxt = 12'h000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_r       <= DSA_AZ;
      div_r      <= 2'h0;
      tot_r      <= TOT_RESET;
      ph_cnt_r   <= 12'h000;
      bcd_r      <= 13'h0000;
      disp_r     <= 13'h0000;
      neg_r      <= 1'b0;
      disp_neg_r <= 1'b0;
    end else begin
      ph_r       <= ph_nxt;
      div_r      <= div_nxt;
      tot_r      <= tot_nxt;
      ph_cnt_r   <= ph_cnt_nxt;
      bcd_r      <= bcd_nxt;
      disp_r     <= disp_nxt;
      neg_r      <= neg_nxt;
      disp_neg_r <= disp_neg_nxt;
    end
  end

  // ---------------------------------------------------------------
  // analog switch controls
  // ---------------------------------------------------------------
  logic az_loop_r, in_conn_r, lo_common_r, ref_pos_r, ref_neg_r;
  logic az_loop_nxt, in_conn_nxt, lo_common_nxt, ref_pos_nxt, ref_neg_nxt;

  always_comb begin
    az_loop_nxt   = (ph_nxt == DSA_AZ);
    in_conn_nxt   = (ph_nxt == DSA_SI);
    lo_common_nxt = (ph_nxt != DSA_SI);
    ref_pos_nxt   = (ph_nxt == DSA_RI) && neg_nxt;
    ref_neg_nxt   = (ph_nxt == DSA_RI) && !neg_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      az_loop_r   <= 1'b1;
      in_conn_r   <= 1'b0;
      lo_common_r <= 1'b1;
      ref_pos_r   <= 1'b0;
      ref_neg_r   <= 1'b0;
    end else begin
      az_loop_r   <= az_loop_nxt;
      in_conn_r   <= in_conn_nxt;
      lo_common_r <= lo_common_nxt;
      ref_pos_r   <= ref_pos_nxt;
      ref_neg_r   <= ref_neg_nxt;
    end
  end

  assign az_loop   = az_loop_r;
  assign in_conn   = in_conn_r;
  assign lo_common = lo_common_r;
  assign ref_pos   = ref_pos_r;
  assign ref_neg   = ref_neg_r;

  // ---------------------------------------------------------------
  // lcd drive
  // ---------------------------------------------------------------
  logic [8:0]       bp_cnt_r, bp_cnt_nxt;
  logic             bp_r, bp_nxt;
  logic [SEG_N-1:0] seg_r, seg_nxt;
  logic [SEG_N-1:0] seg_on;

  always_comb begin
    bp_cnt_nxt = bp_cnt_r + 9'h001;
    bp_nxt     = bp_r;
    if (bp_cnt_r == 9'(BP_HALF - 1)) begin
      bp_cnt_nxt = 9'h000;
      bp_nxt     = ~bp_r;
    end
    // {sign, thousands b/c, hundreds, tens, units}
    seg_on = {disp_neg_r, {2{disp_r[12]}}, dsa_seg7(disp_r[11:8]),
              dsa_seg7(disp_r[7:4]), dsa_seg7(disp_r[3:0])};
    if (lt_s2_r) begin
      seg_on = {SEG_N{1'b1}};
    end
    seg_nxt = seg_on ^ {SEG_N{bp_nxt}};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bp_cnt_r <= 9'h000;
      bp_r     <= 1'b0;
      seg_r    <= {SEG_N{1'b0}};
    end else begin
      bp_cnt_r <= bp_cnt_nxt;
      bp_r     <= bp_nxt;
      seg_r    <= seg_nxt;
    end
  end

  assign backplane = bp_r;
  assign seg       = seg_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_order;
    (ph_r != $past(ph_r)) |-> ((ph_r == DSA_SI && $past(ph_r) == DSA_AZ) ||
      (ph_r == DSA_RI && $past(ph_r) == DSA_SI) || (ph_r == DSA_AZ && $past(ph_r) == DSA_RI));
  endproperty
  a_order: assert property (p_order) else $error("phase order broken");

  property p_div;
    tick |=> !tick ##1 !tick ##1 !tick ##1 tick;
  endproperty
  a_div: assert property (p_div) else $error("count tick not every four clocks");

  property p_az_len;
    (ph_r == DSA_AZ && ph_nxt == DSA_SI) |-> (ph_cnt_r >= 12'(AZ_MIN - 1) && ph_cnt_r <= 12'(AZ_MAX - 1));
  endproperty
  a_az_len: assert property (p_az_len) else $error("auto-zero length out of range");

  property p_si_len;
    (ph_r == DSA_SI && ph_nxt == DSA_RI) |-> (ph_cnt_r == 12'(SI_COUNTS - 1));
  endproperty
  a_si_len: assert property (p_si_len) else $error("integrate length wrong");

  property p_ri_len;
    (ph_r == DSA_RI) |-> (ph_cnt_r < 12'(RI_MAX));
  endproperty
  a_ri_len: assert property (p_ri_len) else $error("deintegrate too long");

  property p_cycle;
    (ph_r == DSA_SI && $past(ph_r) == DSA_AZ) |-> (tot_r == 12'h000 && $past(tot_r) == 12'(CYCLE_COUNTS - 1));
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle not 4000 counts");

  property p_switch;
    az_loop_r |-> (!in_conn_r && lo_common_r && !ref_pos_r && !ref_neg_r);
  endproperty
  a_switch: assert property (p_switch) else $error("inputs connected during auto-zero");

  property p_ref_pol;
    (ref_pos_r || ref_neg_r) |-> (ph_r == DSA_RI && ref_pos_r == neg_r && ref_neg_r == !neg_r);
  endproperty
  a_ref_pol: assert property (p_ref_pol) else $error("reference polarity wrong");

  property p_bp;
    (bp_r != $past(bp_r)) |-> ($past(bp_cnt_r) == 9'(BP_HALF - 1));
  endproperty
  a_bp: assert property (p_bp) else $error("backplane period wrong");

  property p_lamp;
    lt_s2_r |=> (seg_r == {SEG_N{~bp_r}});
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test not all on");

  property p_latch;
    (ph_r == DSA_RI && ph_nxt == DSA_AZ) |=> (disp_r == $past(bcd_r) && disp_neg_r == $past(neg_r));
  endproperty
  a_latch: assert property (p_latch) else $error("reading not latched");

  property p_in_conn;
    in_conn_r |-> (ph_r == DSA_SI && !az_loop_r && !lo_common_r && !ref_pos_r && !ref_neg_r);
  endproperty
  a_in_conn: assert property (p_in_conn) else $error("inputs connected outside integrate");

  property p_bcd;
    (bcd_r[3:0] <= 4'h9 && bcd_r[7:4] <= 4'h9 && bcd_r[11:8] <= 4'h9 && bcd_r <= BCD_MAX);
  endproperty
  a_bcd: assert property (p_bcd) else $error("count not decimal or above full scale");

  property p_sign;
    (!$past(lt_s2_r)) |-> (seg_r[SEG_N-1] == ($past(disp_neg_r) ^ bp_r));
  endproperty
  a_sign: assert property (p_sign) else $error("sign segment drive wrong");

  property p_tot;
    (tot_r < 12'(CYCLE_COUNTS));
  endproperty
  a_tot: assert property (p_tot) else $error("cycle counter past end of cycle");

endmodule : dsa_core

// [rtl/dsa_pkg.sv]
// Contract
// - phases auto-zero, integrate, deintegrate repeat forever
// - oscillator divided by four advances counters
// - auto-zero lasts 1000 to 3000 counts
// - signal integrate lasts exactly 1000 counts
// - deintegrate until comparator zero, 0-2000 counts
// - whole cycle always totals 4000 counts
// - unused deintegrate time extends next auto-zero
// - auto-zero opens inputs, shorts nodes, closes loop
// - leaving auto-zero connects differential inputs
// - polarity latched at end of integrate
// - reference polarity from sign drives toward zero
// - displayed magnitude equals deintegrate count
// - backplane square wave at oscillator over 800
// - segment in phase off, antiphase on
// - minus segment on for negative input
// - lamp test forces all segments on
// - full scale input reads 1999
package dsa_pkg;

  localparam int          OSC_DIV      = 4;
  localparam int          SI_COUNTS    = 1000;
  localparam int          RI_MAX       = 2000;
  localparam int          AZ_MIN       = 1000;
  localparam int          AZ_MAX       = 3000;
  localparam int          CYCLE_COUNTS = 4000;
  localparam int          DISP_MAX     = 1999;
  localparam int          BP_DIV       = 800;
  localparam int          BP_HALF      = BP_DIV / 2;
  localparam int          SEG_N        = 24;
  localparam logic [11:0] TOT_RESET    = 12'(CYCLE_COUNTS - AZ_MIN);
  localparam logic [12:0] BCD_MAX      = 13'h1999;

  typedef enum logic [1:0] {
    DSA_AZ,
    DSA_SI,
    DSA_RI
  } dsa_phase_t;

  // seven-segment pattern {g,f,e,d,c,b,a}
  function automatic logic [6:0] dsa_seg7(input logic [3:0] d);
    logic [6:0] s;
    s = 7'h00;
    case (d)
      4'h0:    s = 7'h3f;
      4'h1:    s = 7'h06;
      4'h2:    s = 7'h5b;
      4'h3:    s = 7'h4f;
      4'h4:    s = 7'h66;
      4'h5:    s = 7'h6d;
      4'h6:    s = 7'h7d;
      4'h7:    s = 7'h07;
      4'h8:    s = 7'h7f;
      4'h9:    s = 7'h6f;
      default: s = 7'h00;
    endcase
    return s;
  endfunction : dsa_seg7

endpackage : dsa_pkg

// [verification/dsa_front_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// integrator and comparator stand-in
// ----------------------------------------
module dsa_front_model (
  // clock
  input  wire logic clk_sys,
  // input level in counts
  input  int        vin,
  // switch controls
  input  wire logic az_loop,
  input  wire logic in_conn,
  input  wire logic ref_pos,
  input  wire logic ref_neg,
  // comparator
  output logic      comp_pos
);
  longint integ = 0;

  // one clk of input adds vin, one clk of reference removes 1000
  always @(posedge clk_sys) begin
    if (in_conn) begin
      integ <= integ + vin;
    end else if (ref_neg) begin
      integ <= integ - 1000;
    end else if (ref_pos) begin
      integ <= integ + 1000;
    end else if (az_loop) begin
      integ <= 0;
    end
  end

  assign comp_pos = integ > 0;
endmodule : dsa_front_model

// [verification/tb_dual_slope_adc_sequencer_lcd.sv]
`timescale 1ns/1ps
module tb_dual_slope_adc_sequencer_lcd
  import dsa_pkg::*;
;
  logic             clk_sys = 1'b0;
  logic             rst_n;
  logic             lamp_test;
  logic             comp_pos, az_loop, in_conn, lo_common, ref_pos, ref_neg, backplane;
  logic [SEG_N-1:0] seg;
  int               vin;
  int               bad_count = 0;
  int               num_checks = 0;
  int               cyc = 0;

  always #4 clk_sys = ~clk_sys;

  dsa_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .comp_pos(comp_pos), .az_loop(az_loop),
    .in_conn(in_conn), .lo_common(lo_common), .ref_pos(ref_pos), .ref_neg(ref_neg),
    .lamp_test(lamp_test), .backplane(backplane), .seg(seg));

  dsa_front_model fe_u (.clk_sys(clk_sys), .vin(vin), .az_loop(az_loop), .in_conn(in_conn),
    .ref_pos(ref_pos), .ref_neg(ref_neg), .comp_pos(comp_pos));

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // segment pattern {g,f,e,d,c,b,a} back to its digit
  function automatic int dig(input logic [6:0] p);
    case (p)
      7'h3f:   return 0;
      7'h06:   return 1;
      7'h5b:   return 2;
      7'h4f:   return 3;
      7'h66:   return 4;
      7'h6d:   return 5;
      7'h7d:   return 6;
      7'h07:   return 7;
      7'h7f:   return 8;
      7'h6f:   return 9;
      default: return -1000;
    endcase
  endfunction : dig

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic show_check(input int e, input logic neg);
    logic [SEG_N-1:0] on;
    int               disp;
    on   = seg ^ {SEG_N{backplane}};
    disp = dig(on[20:14]) * 100 + dig(on[13:7]) * 10 + dig(on[6:0]);
    if (on[22:21] === 2'b11) disp += 1000;
    else if (on[22:21] !== 2'b00) disp = -1;
    chk(disp >= e - 2 && disp <= e + 2, "reading");
    chk(on[23] === neg, "sign segment");
  endtask : show_check

  task automatic run_cycle(input int v, input int nv);
    int si, ri, az, a, d;
    si = 0;
    ri = 0;
    az = 0;
    a  = (v < 0) ? -v : v;
    d  = 4 * ((a > RI_MAX) ? RI_MAX : a);
    chk(az_loop === 1'b0 && lo_common === 1'b0, "integrate switches");
    while (in_conn === 1'b1) begin
      si++;
      @(negedge clk_sys);
    end
    vin <= nv;
    chk(ref_pos === (v < 0) && ref_neg === (v > 0), "reference polarity");
    while ((ref_pos | ref_neg) === 1'b1) begin
      ri++;
      @(negedge clk_sys);
    end
    while (az_loop === 1'b1) begin
      az++;
      if (az == 8) begin
        chk(in_conn === 1'b0 && lo_common === 1'b1, "auto-zero switches");
        show_check((a > DISP_MAX) ? DISP_MAX : a, v < 0);
      end
      @(negedge clk_sys);
    end
    chk(si == 4000, "integrate length");
    chk(ri >= d - 12 && ri <= d + 12, "deintegrate length");
    chk(az >= 4000 && az <= 12000, "auto-zero length");
    chk(si + ri + az == 16000, "cycle length");
  endtask : run_cycle

  task automatic lamp_check();
    logic b;
    int   n;
    n = 0;
    @(posedge clk_sys) lamp_test <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk((seg ^ {SEG_N{backplane}}) === {SEG_N{1'b1}}, "lamp test");
    b = backplane;
    while (backplane === b) @(negedge clk_sys);
    b = backplane;
    while (backplane === b) begin
      n++;
      @(negedge clk_sys);
    end
    chk(n == BP_HALF, "backplane half period");
    chk((seg ^ {SEG_N{backplane}}) === {SEG_N{1'b1}}, "antiphase drive");
    @(posedge clk_sys) lamp_test <= 1'b0;
  endtask : lamp_check

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n     = 1'b0;
    lamp_test = 1'b0;
    vin       = 1234;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    while (in_conn !== 1'b1) @(negedge clk_sys);
    run_cycle(1234, -567);
    run_cycle(-567, 2500);
    run_cycle(2500, 305);
    run_cycle(305, 305);
    lamp_check();
    tally_and_finish();
  end
endmodule : tb_dual_slope_adc_sequencer_lcd
